// ### core/timer_shell.sv
// Compact timer module with clock select, compare, pin control and byte access
//
// Operation
// - Counter compared; match interrupts, clears, drives pin
// - Three-bit field selects counter clock source
// - Reserved code 101 feeds no clock
// - Input pin counts on selectable edge
// - Separate interrupts for comparators A and P
// - Input pin routed only when selected
// - Compare output sets, clears or toggles pin
// - PWM waveform on the same output pin
// - Capture mode makes output pin an input
// - Pin follows on, mode and output settings
// - Pin-function enables for timers 0,1,2
// - Unimplemented pin-function bits read zero
// - High byte direct, low byte via buffer
// - Buffer moves on low-byte write and high-byte read
// - Low-byte compare write fills buffer only
// - High-byte write also loads buffered low
// - High-byte read captures low into buffer
// - Low-byte read returns buffer contents
// - Compact type: compare, timer, PWM modes
// - Clock select occupies bits six to four
`timescale 1ns/1ps
`default_nettype none
module timer_shell
  import timer_shell_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Internal clock enables from the chip
  input  wire logic       high_clock_tick,
  input  wire logic       time_base_tick,
  // External clock input pin
  input  wire logic       timer_clock_input_pin,
  // Timer output pin, two-way
  input  wire logic       timer_output_pin_in,
  output logic            timer_output_pin_out,
  output logic            timer_output_pin_oe,
  // Capture-mode request from sibling timer logic
  input  wire logic       capture_mode,
  // Pin ownership towards the pin-share logic
  output logic            clock_pin_owned,
  output logic [2:0]      pin_enables,
  // Interrupt requests
  output logic            match_a_irq,
  output logic            match_p_irq
);
  initial begin
    if (COUNT_WIDTH != 16) $error("compact timer counter must be 16 bits");
  end

  typedef struct packed {
    logic [7:0]  ctrl_first;
    logic [7:0]  ctrl_second;
    logic [7:0]  cmp_p;
    logic [7:0]  pin_func;
    logic [7:0]  rdata;
    logic [COUNT_WIDTH-1:0] count;
    logic [5:0]  presc_sys;
    logic [5:0]  presc_h;
    logic        out_level;
    logic        on_last;
    logic        irq_a;
    logic        irq_p;
    logic        ck_sync1;
    logic        ck_sync2;
    logic        tp_sync1;
    logic        tp_sync2;
    logic        tp_sample;
  } shell_state_type;
  shell_state_type state_reg;
  shell_state_type state_next;

  logic [2:0]      clk_sel;
  logic            running;
  logic            paused;
  timer_mode_type  mode;
  logic [1:0]      io_sel;
  logic            pin_tick;
  logic            count_tick;
  logic            match_a;
  logic            match_p;
  logic            on_rise;
  logic [15:0]     cmp_a_value;
  logic [7:0]      cnt_buf;
  logic [7:0]      cnt_high;
  logic [7:0]      cmpa_buf;
  logic [7:0]      cmpa_high;
  logic            wr_sel;
  logic            rd_sel;
  logic            pwm_level;
  logic            pwm_active;
  logic            advance;
  logic            pin_used;

  // Decoded control fields
  assign clk_sel = state_reg.ctrl_first[CLK_SEL_MSB:CLK_SEL_LSB];
  assign paused  = state_reg.ctrl_first[CTRL_PAUSE_BIT];
  assign running = state_reg.ctrl_first[CTRL_ON_BIT];
  assign mode    = timer_mode_type'(state_reg.ctrl_second[MODE_MSB:MODE_LSB]);
  assign io_sel  = state_reg.ctrl_second[IO_MSB:IO_LSB];
  assign on_rise = running & ~state_reg.on_last;
  // Counter moves only when on, not paused and fed; a parked counter raises no requests
  assign advance = running && !paused && count_tick;

  // Input pin reaches the timer only when a pin clock is chosen
  assign clock_pin_owned = (clk_sel == CK_PIN_RISE) || (clk_sel == CK_PIN_FALL);

  edge_tick u_pin_edge (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .level_in (state_reg.ck_sync2 & clock_pin_owned),
    .fall_sel (clk_sel == CK_PIN_FALL),
    .tick     (pin_tick)
  );

  // Clock source selection; reserved code gives no ticks
  always_comb begin
    unique case (clk_sel)
      CK_SYS_DIV4: count_tick = &state_reg.presc_sys[DIV4_BIT:0];
      CK_SYS:      count_tick = 1'b1;
      CK_H_DIV16:  count_tick = high_clock_tick & (&state_reg.presc_h[DIV16_BIT:0]);
      CK_H_DIV64:  count_tick = high_clock_tick & (&state_reg.presc_h[DIV64_BIT:0]);
      CK_TBC:      count_tick = time_base_tick;
      CK_RESERVED: count_tick = 1'b0;
      CK_PIN_RISE: count_tick = pin_tick;
      CK_PIN_FALL: count_tick = pin_tick;
    endcase
  end

  // Comparators: A on all bits, P on the top byte
  assign match_a = running && (state_reg.count == cmp_a_value);
  assign match_p = running && (state_reg.count[COUNT_WIDTH-1 -: 8] == state_reg.cmp_p);

  // Register strobes for the byte pairs
  assign wr_sel = reg_wr;
  assign rd_sel = reg_rd;

  byte_pair #(.WIDTH(COUNT_WIDTH)) u_cnt_pair (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .wr_low     (1'b0),
    .wr_high    (1'b0),
    .rd_high    (rd_sel && reg_addr == ADDR_CNT_HIGH),
    .wdata      (reg_wdata),
    .live_sel   (1'b1),
    .live_value (state_reg.count),
    .value      (),
    .buf_byte   (cnt_buf),
    .high_byte  (cnt_high)
  );

  byte_pair #(.WIDTH(16)) u_cmpa_pair (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .wr_low     (wr_sel && reg_addr == ADDR_CMPA_LOW),
    .wr_high    (wr_sel && reg_addr == ADDR_CMPA_HIGH),
    .rd_high    (rd_sel && reg_addr == ADDR_CMPA_HIGH),
    .wdata      (reg_wdata),
    .live_sel   (1'b0),
    .live_value (16'h0000),
    .value      (cmp_a_value),
    .buf_byte   (cmpa_buf),
    .high_byte  (cmpa_high)
  );

  // PWM: active from counter restart until match A; out ctl gives the active level
  // Codes: 00 forced inactive, 01 forced active, 10 waveform, 11 undefined held inactive
  assign pwm_active = state_reg.count < cmp_a_value;
  assign pwm_level  = (io_sel == IO_HIGH) ? (pwm_active ~^ state_reg.ctrl_second[OUT_CTL_BIT]) :
                      (io_sel == IO_LOW)  ? state_reg.ctrl_second[OUT_CTL_BIT] :
                                            ~state_reg.ctrl_second[OUT_CTL_BIT];

  // Next-state logic: registers, prescalers, counter, pin level
  always_comb begin
    state_next         = state_reg;
    state_next.on_last = running;
    state_next.irq_a   = match_a && advance;
    state_next.irq_p   = match_p && advance;
    // Pin inputs pass two flops first
    state_next.ck_sync1 = timer_clock_input_pin;
    state_next.ck_sync2 = state_reg.ck_sync1;
    state_next.tp_sync1 = timer_output_pin_in;
    state_next.tp_sync2 = state_reg.tp_sync1;
    if (capture_mode && pin_used) begin
      state_next.tp_sample = state_reg.tp_sync2;
    end
    // Free-running prescalers
    state_next.presc_sys = 6'(state_reg.presc_sys + 6'h01);
    if (high_clock_tick) begin
      state_next.presc_h = 6'(state_reg.presc_h + 6'h01);
    end
    // Counter
    if (on_rise) begin
      state_next.count = '0;
      if (mode == MODE_COMPARE) begin
        state_next.out_level = state_reg.ctrl_second[OUT_CTL_BIT];
      end
    end else if (advance) begin
      if ((match_a && state_reg.ctrl_second[CCLR_BIT]) || (match_p && !state_reg.ctrl_second[CCLR_BIT])) begin
        state_next.count = '0;
      end else begin
        state_next.count = COUNT_WIDTH'(state_reg.count + 1'b1);
      end
      // Output action on comparator A match
      if (match_a && mode == MODE_COMPARE) begin
        unique case (io_sel)
          IO_NONE:   state_next.out_level = state_reg.out_level;
          IO_LOW:    state_next.out_level = 1'b0;
          IO_HIGH:   state_next.out_level = 1'b1;
          IO_TOGGLE: state_next.out_level = ~state_reg.out_level;
        endcase
      end
    end
    // Software writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL_FIRST:  state_next.ctrl_first  = reg_wdata & CTRL_FIRST_MASK;
        ADDR_CTRL_SECOND: state_next.ctrl_second = reg_wdata;
        ADDR_CMPP:        state_next.cmp_p       = reg_wdata;
        ADDR_PIN_FUNC:    state_next.pin_func    = reg_wdata & PIN_FUNC_MASK;
        default:          state_next.rdata       = state_reg.rdata;
      endcase
    end
    // Read data stands in the cycle after the strobe only
    state_next.rdata = RESET_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL_FIRST:  state_next.rdata = state_reg.ctrl_first;
        ADDR_CTRL_SECOND: state_next.rdata = state_reg.ctrl_second;
        ADDR_CNT_LOW:     state_next.rdata = cnt_buf;
        ADDR_CNT_HIGH:    state_next.rdata = cnt_high;
        ADDR_CMPA_LOW:    state_next.rdata = cmpa_buf;
        ADDR_CMPA_HIGH:   state_next.rdata = cmpa_high;
        ADDR_CMPP:        state_next.rdata = state_reg.cmp_p;
        ADDR_PIN_FUNC:    state_next.rdata = state_reg.pin_func & PIN_FUNC_MASK;
        ADDR_STATUS:      state_next.rdata = {5'h00, state_reg.tp_sample, state_reg.out_level, running};
        default:          state_next.rdata = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pin enables per timer, timer 0 in bit 0
  assign pin_enables = state_reg.pin_func[2:0];

  // Output pin used only when on and configured to drive
  assign pin_used = state_reg.pin_func[2] & running & (mode != MODE_TIMER) & (mode != MODE_UNDEF);

  // Output drive: compare level or PWM waveform on one pin
  assign timer_output_pin_oe  = pin_used & ~capture_mode;
  assign timer_output_pin_out = (mode == MODE_PWM) ? pwm_level : state_reg.out_level;

  assign reg_rdata   = state_reg.rdata;
  assign match_a_irq = state_reg.irq_a;
  assign match_p_irq = state_reg.irq_p;
endmodule : timer_shell
`default_nettype wire

// ### core/timer_shell_pkg.sv
// Package of register map, field layout and encodings for the timer shell
package timer_shell_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL_FIRST  = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECOND = 4'h1;
  localparam logic [3:0] ADDR_CNT_LOW     = 4'h2;
  localparam logic [3:0] ADDR_CNT_HIGH    = 4'h3;
  localparam logic [3:0] ADDR_CMPA_LOW    = 4'h4;
  localparam logic [3:0] ADDR_CMPA_HIGH   = 4'h5;
  localparam logic [3:0] ADDR_CMPP        = 4'h6;
  localparam logic [3:0] ADDR_PIN_FUNC    = 4'h7;
  localparam logic [3:0] ADDR_STATUS      = 4'h8;
  // Field positions in the first control register
  localparam int CTRL_PAUSE_BIT = 7;
  localparam int CLK_SEL_MSB    = 6;
  localparam int CLK_SEL_LSB    = 4;
  localparam int CTRL_ON_BIT    = 3;
  // Field positions in the second control register
  localparam int MODE_MSB    = 7;
  localparam int MODE_LSB    = 6;
  localparam int IO_MSB      = 5;
  localparam int IO_LSB      = 4;
  localparam int OUT_CTL_BIT = 3;
  localparam int CCLR_BIT    = 0;
  // Implemented bits of the pin-function and first control registers, and the idle read byte
  localparam logic [7:0] PIN_FUNC_MASK  = 8'h87;
  localparam logic [7:0] CTRL_FIRST_MASK = 8'hF8;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  // Counter clock selection codes
  localparam logic [2:0] CK_SYS_DIV4  = 3'h0;
  localparam logic [2:0] CK_SYS       = 3'h1;
  localparam logic [2:0] CK_H_DIV16   = 3'h2;
  localparam logic [2:0] CK_H_DIV64   = 3'h3;
  localparam logic [2:0] CK_TBC       = 3'h4;
  localparam logic [2:0] CK_RESERVED  = 3'h5;
  localparam logic [2:0] CK_PIN_RISE  = 3'h6;
  localparam logic [2:0] CK_PIN_FALL  = 3'h7;
  // Prescaler taps
  localparam int DIV4_BIT  = 1;
  localparam int DIV8_BIT  = 2;
  localparam int DIV16_BIT = 3;
  localparam int DIV64_BIT = 5;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_UNDEF   = 2'h1,
    MODE_PWM     = 2'h2,
    MODE_TIMER   = 2'h3
  } timer_mode_type;
  // Compare output actions
  localparam logic [1:0] IO_NONE   = 2'h0;
  localparam logic [1:0] IO_LOW    = 2'h1;
  localparam logic [1:0] IO_HIGH   = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
endpackage : timer_shell_pkg

// ### core/edge_tick.sv
// Tick generator: one-cycle pulse on a chosen edge of a slow level
`timescale 1ns/1ps
`default_nettype none
module edge_tick (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Level to watch, same domain
  input  wire logic level_in,
  input  wire logic fall_sel,
  // Pulse out
  output logic      tick
);
  typedef struct packed {
    logic last;
  } edge_state_type;
  edge_state_type state_reg;
  edge_state_type state_next;

  // Remember the previous level
  always_comb begin
    state_next      = state_reg;
    state_next.last = level_in;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Rising or falling edge per selection
  assign tick = fall_sel ? (state_reg.last & ~level_in) : (~state_reg.last & level_in);
endmodule : edge_tick
`default_nettype wire

// ### core/byte_pair.sv
// Buffered low/high byte register pair with shared byte buffer
`timescale 1ns/1ps
`default_nettype none
module byte_pair #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Software accesses
  input  wire logic             wr_low,
  input  wire logic             wr_high,
  input  wire logic             rd_high,
  input  wire logic [7:0]       wdata,
  // Live value for a read-only pair
  input  wire logic             live_sel,
  input  wire logic [WIDTH-1:0] live_value,
  // Stored value and read-back
  output logic [WIDTH-1:0]      value,
  output logic [7:0]            buf_byte,
  output logic [7:0]            high_byte
);
  initial begin
    if (WIDTH <= 8 || WIDTH > 16) $error("byte_pair WIDTH must be 9..16");
  end

  typedef struct packed {
    logic [WIDTH-1:0] value;
    logic [7:0]       buffer;
  } pair_state_type;
  pair_state_type state_reg;
  pair_state_type state_next;
  logic [WIDTH-1:0] src;

  assign src = live_sel ? live_value : state_reg.value;

  // Buffer moves on a low-byte write or a high-byte read
  always_comb begin
    state_next = state_reg;
    if (wr_low) begin
      state_next.buffer = wdata;
    end
    if (wr_high) begin
      state_next.value = {wdata[WIDTH-9:0], state_reg.buffer};
    end
    if (rd_high) begin
      state_next.buffer = src[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value     = state_reg.value;
  assign buf_byte  = state_reg.buffer;
  assign high_byte = 8'(src[WIDTH-1:8]);
endmodule : byte_pair
`default_nettype wire

// ### sim/timer_shell_assertions.sv
// Port-level checks for the timer shell
`timescale 1ns/1ps
`default_nettype none
module timer_shell_assertions
  import timer_shell_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and requests
  input wire logic       capture_mode,
  input wire logic       timer_output_pin_oe,
  input wire logic       clock_pin_owned,
  input wire logic [2:0] pin_enables,
  input wire logic       match_a_irq,
  input wire logic       match_p_irq
);
  logic [7:0] c0_q;
  logic [7:0] pf_q;
  logic [7:0] ah_q;
  logic [3:0] idle_cnt;
  logic       quiet;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Stopped when off, paused or fed by the reserved code
  assign quiet = (c0_q[6:4] == CK_RESERVED) || !c0_q[3] || c0_q[7];

  // Shadows of written registers; the counter saturates so it never wraps
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      c0_q     <= 8'h00;
      pf_q     <= 8'h00;
      ah_q     <= 8'h00;
      idle_cnt <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == ADDR_CTRL_FIRST) c0_q <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_PIN_FUNC) pf_q <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_CMPA_HIGH) ah_q <= reg_wdata;
      idle_cnt <= !quiet ? 4'h0 : (idle_cnt == 4'hF ? idle_cnt : idle_cnt + 4'h1);
    end
  end

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  pin_func_read_a: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_PIN_FUNC
    |-> reg_rdata == (pf_q & PIN_FUNC_MASK)) else $error("pin-function read-back wrong");
  ctrl_first_read_a: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_CTRL_FIRST
    |-> reg_rdata == (c0_q & CTRL_FIRST_MASK)) else $error("first control read-back wrong");
  cmpa_high_read_a: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_CMPA_HIGH
    |-> reg_rdata == ah_q) else $error("compare high byte read wrong");
  pin_enable_out_a: assert property (pin_enables == pf_q[2:0])
    else $error("pin enables differ from written bits");
  clock_pin_own_a: assert property (clock_pin_owned == (c0_q[6:5] == 2'b11))
    else $error("clock pin ownership wrong");
  idle_no_irq_a: assert property (idle_cnt >= 4'h4 |-> !match_a_irq && !match_p_irq)
    else $error("match request while counter has no clock");
  pin_off_oe_a: assert property (!pin_enables[2] && !$past(pin_enables[2]) |-> !timer_output_pin_oe)
    else $error("output pin driven while not owned");
  capture_oe_a: assert property (capture_mode && $past(capture_mode) && $past(capture_mode, 2)
    |-> !timer_output_pin_oe) else $error("output pin driven in capture mode");
endmodule : timer_shell_assertions
`default_nettype wire

// ### sim/timer_shell_tb.sv
// Self-checking bench for the timer shell
`timescale 1ns/1ps
`default_nettype none
module timer_shell_tb
  import timer_shell_pkg::*;
;
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        hi_tick   = 1'b0;
  logic        tb_tick   = 1'b0;
  logic        ck_pin    = 1'b0;
  logic        tp_in     = 1'b0;
  logic        cap       = 1'b0;
  logic [7:0]  reg_rdata;
  logic        tp_out;
  logic        tp_oe;
  logic        owned;
  logic [2:0]  pin_en;
  logic        irq_a;
  logic        irq_p;
  logic [7:0]  d;
  logic [7:0]  h;
  logic [15:0] c1;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          na;
  int          np;
  int          nt;

  timer_shell #(.COUNT_WIDTH(16)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .high_clock_tick(hi_tick), .time_base_tick(tb_tick), .timer_clock_input_pin(ck_pin),
    .timer_output_pin_in(tp_in), .timer_output_pin_out(tp_out), .timer_output_pin_oe(tp_oe),
    .capture_mode(cap), .clock_pin_owned(owned), .pin_enables(pin_en),
    .match_a_irq(irq_a), .match_p_irq(irq_p)
  );

  always #5 clk_sys = ~clk_sys;

  // Internal clock enables, pin loop-back and the hang guard
  always @(posedge clk_sys) begin
    cyc     <= cyc + 1;
    hi_tick <= (cyc % 4 == 0);
    tb_tick <= (cyc % 16 == 0);
    tp_in   <= tp_oe ? tp_out : ~tp_out; // Released pin reads back inverted, so capture sees a change
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Answer stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string n);
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask : rdc

  // High byte first, so the low byte comes from the same snapshot
  task automatic cnt16(input logic [15:0] e, input string n);
    rd(ADDR_CNT_HIGH, h);
    rd(ADDR_CNT_LOW, d);
    chk(n, e, {h, d});
  endtask : cnt16

  // Off then on, which clears the counter
  task automatic restart(input logic [7:0] c0);
    wr(ADDR_CTRL_FIRST, 8'h00);
    wr(ADDR_CTRL_FIRST, c0);
  endtask : restart

  // Slow pulses so the two-flop synchroniser sees every edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ck_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ck_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask : pulses

  task automatic watch(input int n);
    logic last;
    na   = 0;
    np   = 0;
    nt   = 0;
    last = tp_out;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      na += int'(irq_a);
      np += int'(irq_p);
      nt += int'(tp_out !== last);
      last = tp_out;
    end
  endtask : watch

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(ADDR_PIN_FUNC, RESET_BYTE, "pin_func_reset");
    rdc(ADDR_CTRL_FIRST, RESET_BYTE, "ctrl_first_reset");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_PIN_FUNC, 8'h01 << i);
      #1 chk("pin_enables", 16'(8'h01 << i), {13'h0000, pin_en});
    end
    wr(ADDR_PIN_FUNC, 8'hFF);
    rdc(ADDR_PIN_FUNC, PIN_FUNC_MASK, "pin_func_mask");
    rdc(4'hF, 8'h00, "unmapped");
    $display("test pin_function done");
    wr(ADDR_CMPA_LOW, 8'h34);
    rdc(ADDR_CMPA_LOW, 8'h34, "cmpa_buffer");
    rdc(ADDR_CMPA_HIGH, 8'h00, "cmpa_high_old");
    rdc(ADDR_CMPA_LOW, 8'h00, "cmpa_low_kept");
    wr(ADDR_CMPA_LOW, 8'h09);
    wr(ADDR_CMPA_HIGH, 8'h12);
    rdc(ADDR_CMPA_HIGH, 8'h12, "cmpa_high");
    rdc(ADDR_CMPA_LOW, 8'h09, "cmpa_low");
    wr(ADDR_CMPA_LOW, 8'h77);
    rdc(ADDR_CMPA_HIGH, 8'h12, "cmpa_high_again");
    rdc(ADDR_CMPA_LOW, 8'h09, "cmpa_low_unmoved");
    wr(ADDR_CMPA_HIGH, 8'h00);
    $display("test byte_pair done");
    // Clear on A at 9 and park P out of reach before counting
    wr(ADDR_CMPP, 8'hFF);
    wr(ADDR_CTRL_SECOND, 8'h31);
    restart(8'h58);
    repeat (20) @(posedge clk_sys);
    cnt16(16'h0000, "count_reserved");
    restart(8'h18);
    wr(ADDR_CTRL_FIRST, 8'h98);
    rd(ADDR_CNT_HIGH, h);
    rd(ADDR_CNT_LOW, d);
    c1 = {h, d};
    chk("count_runs", 16'h0001, {15'h0000, c1 != 16'h0000});
    repeat (10) @(posedge clk_sys);
    cnt16(c1, "count_paused");
    rdc(ADDR_CTRL_FIRST, 8'h98, "ctrl_first");
    chk("pin_not_owned", 16'h0000, {15'h0000, owned});
    restart(8'h68);
    #1 chk("pin_owned", 16'h0001, {15'h0000, owned});
    pulses(5);
    cnt16(16'h0005, "count_rising");
    restart(8'h78);
    pulses(3);
    cnt16(16'h0003, "count_falling");
    // System clock over four: 21 counting edges give five or six ticks
    restart(8'h08);
    repeat (20) @(posedge clk_sys);
    wr(ADDR_CTRL_FIRST, 8'h88);
    rd(ADDR_CNT_HIGH, h);
    rd(ADDR_CNT_LOW, d);
    chk("count_div4", 16'h0001, {15'h0000, {h, d} >= 16'h0005 && {h, d} <= 16'h0006});
    $display("test clock_select done");
    wr(ADDR_PIN_FUNC, 8'h04);
    restart(8'h18);
    watch(100);
    chk("irq_a_rate", 16'h0001, {15'h0000, na >= 9 && na <= 11});
    chk("irq_p_quiet", 16'h0000, 16'(np));
    chk("pin_toggles", 16'h0001, {15'h0000, nt >= na - 1 && nt <= na + 1});
    chk("pin_driven", 16'h0001, {15'h0000, tp_oe});
    wr(ADDR_CMPP, 8'h01);
    wr(ADDR_CTRL_SECOND, 8'h30);
    restart(8'h18);
    watch(300);
    chk("irq_p_once", 16'h0001, 16'(np));
    $display("test compare done");
    // Restart sets the compare level to out ctl low, then park the counter
    restart(8'h18);
    wr(ADDR_CTRL_FIRST, 8'h98);
    @(posedge clk_sys);
    cap <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("capture_oe", 16'h0000, {15'h0000, tp_oe});
    rdc(ADDR_STATUS, 8'h05, "capture_sample");
    @(posedge clk_sys);
    cap <= 1'b0;
    $display("test capture done");
    // PWM active high, waveform code, period on P
    wr(ADDR_CTRL_SECOND, 8'hA8);
    restart(8'h18);
    repeat (3) @(posedge clk_sys);
    #1 chk("pwm_active", 16'h0001, {15'h0000, tp_out});
    repeat (20) @(posedge clk_sys);
    #1 chk("pwm_inactive", 16'h0000, {15'h0000, tp_out});
    wr(ADDR_CTRL_SECOND, 8'hC0);
    #1 chk("timer_mode_oe", 16'h0000, {15'h0000, tp_oe});
    $display("test pwm done");
    summarize();
  end
endmodule : timer_shell_tb

bind timer_shell timer_shell_assertions #(.COUNT_WIDTH(COUNT_WIDTH)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_mode(capture_mode),
  .timer_output_pin_oe(timer_output_pin_oe), .clock_pin_owned(clock_pin_owned),
  .pin_enables(pin_enables), .match_a_irq(match_a_irq), .match_p_irq(match_p_irq)
);
`default_nettype wire
